// file: hw/obdc_regs.svh
// register offsets, field positions, reset values for the output six bank
`ifndef OBDC_REGS_SVH
`define OBDC_REGS_SVH
`define OBDC_ADDR_W 8
`define OBDC_OFF_Q5_HI_C1 8'h5b
`define OBDC_OFF_DRIVE6 8'h5c
`define OBDC_OFF_Q6_LO_PM 8'h5d
`define OBDC_OFF_Q6_HI_C0 8'h5e
`define OBDC_OFF_Q6_HI_C1 8'h5f
`define OBDC_RST_Q5_HI_C1 8'h00
`define OBDC_RST_DRIVE6 8'h03
`define OBDC_RST_Q6_LO_PM 8'hbb
`define OBDC_RST_Q6_HI_C0 8'h00
`define OBDC_RST_Q6_HI_C1 8'h00
`define OBDC_DIS_MSB 7
`define OBDC_DIS_LSB 6
`define OBDC_SLEW_MSB 5
`define OBDC_SLEW_LSB 4
`define OBDC_INV_BIT 2
`define OBDC_PM_C0_MSB 1
`define OBDC_PM_C0_LSB 0
`define OBDC_QLO_C0_MSB 3
`define OBDC_QLO_C0_LSB 2
`define OBDC_PM_C1_MSB 5
`define OBDC_PM_C1_LSB 4
`define OBDC_QLO_C1_MSB 7
`define OBDC_QLO_C1_LSB 6
`define OBDC_HALF_W 11
`endif

// file: hw/obdc_pkg.sv
// types for the output six bank
package obdc_pkg;
  typedef enum logic [1:0] {
    OBDC_MODE_OFF = 2'b00,
    OBDC_MODE_BYPASS = 2'b01,
    OBDC_MODE_DIV2 = 2'b10,
    OBDC_MODE_DIVQ = 2'b11
  } obdc_mode_t;
  typedef enum logic [1:0] {
    OBDC_DIS_TRI0 = 2'b00,
    OBDC_DIS_TRI1 = 2'b01,
    OBDC_DIS_LOW = 2'b10,
    OBDC_DIS_HIGH = 2'b11
  } obdc_dis_t;
endpackage : obdc_pkg

// file: hw/obdc_divider.sv
// glitch-free output divider, settings taken only at period boundaries or while stopped
`timescale 1ns/100ps
`include "obdc_regs.svh"
module obdc_divider
  import obdc_pkg::*;
#(
  parameter int QW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic [QW-1:0] divval,
  output logic clk_o_r
);
  initial begin
    if (QW < 1 || QW + 1 > `OBDC_HALF_W) begin
      $error("obdc_divider: QW out of range");
    end
  end
  obdc_mode_t mode_r;
  logic [QW-1:0] divval_r;
  logic [`OBDC_HALF_W-1:0] cnt_r;
  logic [`OBDC_HALF_W-1:0] half;
  logic last;
  logic boundary;
  assign half = (mode_r == OBDC_MODE_BYPASS) ? `OBDC_HALF_W'(1) :
                (mode_r == OBDC_MODE_DIV2) ? `OBDC_HALF_W'(2) :
                `OBDC_HALF_W'(divval_r) + `OBDC_HALF_W'(2);
  assign last = (cnt_r == half - `OBDC_HALF_W'(1));
  // new settings only after a full low phase, or while stopped
  assign boundary = (mode_r == OBDC_MODE_OFF) || (last && clk_o_r == 1'b0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= OBDC_MODE_DIVQ;
      divval_r <= '0;
      cnt_r <= '0;
      clk_o_r <= 1'b0;
    end else if (boundary) begin
      mode_r <= obdc_mode_t'(mode);
      divval_r <= divval;
      cnt_r <= '0;
      clk_o_r <= (mode != 2'b00);
    end else if (last) begin
      cnt_r <= '0;
      clk_o_r <= ~clk_o_r;
    end else begin
      cnt_r <= cnt_r + `OBDC_HALF_W'(1);
    end
  end
endmodule : obdc_divider

// file: hw/obdc_top.sv
// output six bank configuration registers and output control
`timescale 1ns/100ps
`include "obdc_regs.svh"
module obdc_top
  import obdc_pkg::*;
#(
  parameter int QW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`OBDC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  input wire logic second_configuration,
  input wire logic out_six_enable_bit,
  input wire logic shutdown_or_enable_pin,
  input wire logic [1:0] out_five_divide_mode_c0,
  input wire logic [1:0] out_five_divide_mode_c1,
  output logic out_five_enable_r,
  output logic [7:0] out_five_divider_high_c1_r,
  output logic clock_output_six_r,
  output logic clock_output_six_oe_n_r,
  output logic [1:0] out_six_edge_rate_r
);

  initial begin
    if (QW != 10) begin
      $error("obdc_top: register layout serves a 10-bit divider only");
    end
    if (`OBDC_ADDR_W < 7) begin
      $error("obdc_top: address too narrow for the register map");
    end
  end

  // register storage
  logic [7:0] q5_hi_c1_r;
  logic [7:0] drive6_r;
  logic [7:0] q6_lo_pm_r;
  logic [7:0] q6_hi_c0_r;
  logic [7:0] q6_hi_c1_r;

  // pin synchroniser stages
  logic pin_meta_r;
  logic pin_sync_r;

  // divider clock before inversion and parking
  logic div_clk;

  // address decode
  wire sel_q5 = (reg_addr == `OBDC_OFF_Q5_HI_C1);
  wire sel_drv = (reg_addr == `OBDC_OFF_DRIVE6);
  wire sel_lo = (reg_addr == `OBDC_OFF_Q6_LO_PM);
  wire sel_hc0 = (reg_addr == `OBDC_OFF_Q6_HI_C0);
  wire sel_hc1 = (reg_addr == `OBDC_OFF_Q6_HI_C1);

  // per-register write strobes
  wire wr_q5 = reg_wr && sel_q5;
  wire wr_drv = reg_wr && sel_drv;
  wire wr_lo = reg_wr && sel_lo;
  wire wr_hc0 = reg_wr && sel_hc0;
  wire wr_hc1 = reg_wr && sel_hc1;

  // read selection, unmapped reads give zero
  wire [7:0] rd_mux = sel_q5 ? q5_hi_c1_r :
                      sel_drv ? drive6_r :
                      sel_lo ? q6_lo_pm_r :
                      sel_hc0 ? q6_hi_c0_r :
                      sel_hc1 ? q6_hi_c1_r : 8'h00;

  // divider fields of both configurations
  wire [1:0] pm_c0 = q6_lo_pm_r[`OBDC_PM_C0_MSB:`OBDC_PM_C0_LSB];
  wire [1:0] pm_c1 = q6_lo_pm_r[`OBDC_PM_C1_MSB:`OBDC_PM_C1_LSB];
  wire [QW-1:0] q_c0 = {q6_hi_c0_r, q6_lo_pm_r[`OBDC_QLO_C0_MSB:`OBDC_QLO_C0_LSB]};
  wire [QW-1:0] q_c1 = {q6_hi_c1_r, q6_lo_pm_r[`OBDC_QLO_C1_MSB:`OBDC_QLO_C1_LSB]};

  // active configuration
  wire [1:0] act_mode = second_configuration ? pm_c1 : pm_c0;
  wire [QW-1:0] act_q = second_configuration ? q_c1 : q_c0;

  // drive control fields
  wire [1:0] dis_beh = drive6_r[`OBDC_DIS_MSB:`OBDC_DIS_LSB];
  wire out_six_invert = drive6_r[`OBDC_INV_BIT];
  wire [1:0] edge_nxt = drive6_r[`OBDC_SLEW_MSB:`OBDC_SLEW_LSB];

  // enable conditions
  wire six_modes_ok = (pm_c0 != 2'b00) && (pm_c1 != 2'b00);
  wire five_modes_ok = (out_five_divide_mode_c0 != 2'b00) && (out_five_divide_mode_c1 != 2'b00);
  wire six_on = six_modes_ok && out_six_enable_bit && pin_sync_r;

  // output divider
  obdc_divider #(
    .QW(QW)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .mode(act_mode),
    .divval(act_q),
    .clk_o_r(div_clk)
  );

  // output level and driver enable
  wire park_level = (obdc_dis_t'(dis_beh) == OBDC_DIS_HIGH);
  wire park_drive = dis_beh[1];
  wire out_nxt = six_on ? (div_clk ^ out_six_invert) : park_level;
  wire oe_n_nxt = ~(six_on | park_drive);

  // one short process per register, reserved drive bits stored as written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q5_hi_c1_r <= `OBDC_RST_Q5_HI_C1;
    end else if (wr_q5) begin
      q5_hi_c1_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive6_r <= `OBDC_RST_DRIVE6;
    end else if (wr_drv) begin
      drive6_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q6_lo_pm_r <= `OBDC_RST_Q6_LO_PM;
    end else if (wr_lo) begin
      q6_lo_pm_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q6_hi_c0_r <= `OBDC_RST_Q6_HI_C0;
    end else if (wr_hc0) begin
      q6_hi_c0_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q6_hi_c1_r <= `OBDC_RST_Q6_HI_C1;
    end else if (wr_hc1) begin
      q6_hi_c1_r <= reg_wdata;
    end
  end

  // read data, held between reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end
  end

  // pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= shutdown_or_enable_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_output_six_r <= 1'b0;
    end else begin
      clock_output_six_r <= out_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_output_six_oe_n_r <= 1'b1;
    end else begin
      clock_output_six_oe_n_r <= oe_n_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_six_edge_rate_r <= 2'b00;
    end else begin
      out_six_edge_rate_r <= edge_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_five_enable_r <= 1'b0;
    end else begin
      out_five_enable_r <= five_modes_ok;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_five_divider_high_c1_r <= `OBDC_RST_Q5_HI_C1;
    end else begin
      out_five_divider_high_c1_r <= q5_hi_c1_r;
    end
  end
endmodule : obdc_top

// file: tb/obdc_top_props.sv
// port checker for the output six bank
`timescale 1ns/100ps
module obdc_top_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic out_six_enable_bit,
  input wire logic [1:0] out_five_divide_mode_c0,
  input wire logic [1:0] out_five_divide_mode_c1,
  input wire logic out_five_enable_r,
  input wire logic [7:0] out_five_divider_high_c1_r,
  input wire logic clock_output_six_r,
  input wire logic clock_output_six_oe_n_r,
  input wire logic [1:0] out_six_edge_rate_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire mapped = reg_addr >= 8'h5b && reg_addr <= 8'h5f;
  a_five_enable:
    assert property (1 |=> out_five_enable_r == ($past(out_five_divide_mode_c0) != 2'b00
      && $past(out_five_divide_mode_c1) != 2'b00)) else $error("out five enable wrong");
  a_edge_rate_out:
    assert property (reg_wr && reg_addr == 8'h5c |=> ##1 {2'b00, out_six_edge_rate_r, 4'h0}
      == ($past(reg_wdata, 2) & 8'h30)) else $error("edge rate not passed");
  a_five_div_copy:
    assert property (reg_wr && reg_addr == 8'h5b |=> ##1 out_five_divider_high_c1_r == $past(reg_wdata, 2))
      else $error("five divider copy wrong");
  a_write_readback:
    assert property (reg_wr && !reg_rd && mapped ##1 reg_rd && !reg_wr && $stable(reg_addr)
      |=> reg_rdata_r == $past(reg_wdata, 2)) else $error("readback mismatch");
  a_unmapped_zero:
    assert property (reg_rd && !mapped |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold:
    assert property (!reg_rd |=> $stable(reg_rdata_r)) else $error("read data moved");
  a_tristate_low:
    assert property (clock_output_six_oe_n_r |-> !clock_output_six_r) else $error("tristate not low");
  a_disabled_static:
    assert property ((!out_six_enable_bit && !reg_wr) [*3] |-> $stable(clock_output_six_r)
      && $stable(clock_output_six_oe_n_r)) else $error("disabled output moved");
  c_five_on: cover property (out_five_enable_r);
  c_park_high: cover property (!clock_output_six_oe_n_r && !out_six_enable_bit && clock_output_six_r);
  c_readback: cover property (reg_wr ##1 reg_rd);
endmodule : obdc_top_props

// file: tb/test_output_bank_divider_config.sv
// register and output tests for the output six bank
`timescale 1ns/100ps
module test_output_bank_divider_config
  import obdc_pkg::*;
;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, second_configuration = 0;
  logic out_six_enable_bit = 1, shutdown_or_enable_pin = 1, out_five_enable_r;
  logic clock_output_six_r, clock_output_six_oe_n_r;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r, out_five_divider_high_c1_r;
  logic [1:0] out_five_divide_mode_c0 = 2'h0, out_five_divide_mode_c1 = 2'h0, out_six_edge_rate_r;
  logic [7:0] rv [5] = '{8'h00, 8'h03, 8'hbb, 8'h00, 8'h00};
  int n_fail = 0, tests_run = 0;
  obdc_top dut_u (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
    chk(reg_rdata_r, e);
  endtask : rd
  task automatic per(input logic [7:0] e);
    int k = 0;
    repeat (30) @(negedge clk);
    while (clock_output_six_r !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    while (clock_output_six_r !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (clock_output_six_r === 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk(8'(k), e);
  endtask : per
  task automatic min_run(input logic [7:0] e);
    int run = 0;
    int best = 255;
    bit seen = 0;
    logic prev;
    prev = clock_output_six_r;
    repeat (40) begin
      @(negedge clk);
      run++;
      if (clock_output_six_r !== prev) begin
        if (seen && run < best) begin
          best = run;
        end
        seen = 1;
        run = 0;
        prev = clock_output_six_r;
      end
    end
    chk(8'(best), e);
  endtask : min_run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    foreach (rv[i]) rd(8'h5b + 8'(i), rv[i]);
    rd(8'h5a, 8'h00);
    wr(8'h60, 8'hff);
    rd(8'h60, 8'h00);
    per(8'h04);
    for (int i = 0; i < 16; i++) begin // out five enable set only when both out five divide modes are non-zero
      out_five_divide_mode_c0 = i[1:0];
      out_five_divide_mode_c1 = i[3:2];
      repeat (2) @(negedge clk);
      chk(8'(out_five_enable_r), 8'(i[1:0] != 0 && i[3:2] != 0));
    end
    wr(8'h5b, 8'ha5);
    rd(8'h5b, 8'ha5);
    chk(out_five_divider_high_c1_r, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      wr(8'h5c, {2'h0, i[1:0], 4'h3});
      repeat (2) @(negedge clk);
      chk(8'(out_six_edge_rate_r), 8'(i[1:0]));
    end
    out_six_enable_bit = 0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h5c, {i[1:0], 6'h03});
      repeat (4) @(negedge clk);
      chk(8'({clock_output_six_oe_n_r, clock_output_six_r}), 8'({~i[1], i[1] & i[0]}));
    end
    out_six_enable_bit = 1;
    shutdown_or_enable_pin = 0;
    repeat (6) @(negedge clk);
    chk(8'({clock_output_six_oe_n_r, clock_output_six_r}), 8'h01);
    shutdown_or_enable_pin = 1;
    wr(8'h5c, 8'h03);
    @(negedge clk);
    wr(8'h5d, 8'h1f);
    per(8'h05);
    wr(8'h5c, 8'h07);
    @(negedge clk);
    chk(8'(clock_output_six_r), 8'h01);
    second_configuration = 1;
    per(8'h01);
    wr(8'h5d, 8'h21);
    per(8'h02);
    second_configuration = 0;
    per(8'h01);
    wr(8'h5d, 8'h2f);
    per(8'h05);
    second_configuration = 1;
    min_run(8'h02);
    wr(8'h5d, 8'h01);
    repeat (20) @(negedge clk);
    chk(8'({clock_output_six_oe_n_r, clock_output_six_r}), 8'h02);
    wrap_up;
  end
endmodule : test_output_bank_divider_config
bind obdc_top obdc_top_props chk_u (.*);
